// >>> hdl/gms_prealloc.sv
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/10ps
`include "gms_cfg.svh"
module gms_prealloc
    import gms_pkg::*;
(
    // Clock and reset
    input  wire logic        i_mclk,
    input  wire logic        i_rst,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Decoded reservation, lock and graphics disable levels
    output logic      [8:0]  o_fb_size_mb,
    output logic             o_claim_vga,
    output logic      [7:0]  o_subclass,
    output logic             o_locked,
    output logic             o_gfx_disable
);

    // ============================================================
    // State and decoder link
    ctrl_state_t s_q;     // Registered state
    ctrl_state_t s_d;     // Next state
    gms_if       sel_if (); // Code to decoder

    // Address is mapped
    function automatic logic mapped(input logic [11:0] a);
        mapped = (a == `GMS_OFS_GFX_CTRL) || (a == `GMS_OFS_LOCK_CTRL) ||
                 (a == `GMS_OFS_STATUS);
    endfunction

    logic        acc_done;  // Access completes this edge
    logic [31:0] rd_word;   // Read mux
    logic [3:0]  wr_sel;    // Write data select field

    assign acc_done = i_psel && i_penable && s_q.pready;
    assign wr_sel   = i_pwdata[`GMS_SEL_MSB:`GMS_SEL_LSB];

    // ============================================================
    // Read mux
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (i_paddr)
            `GMS_OFS_GFX_CTRL:
            begin
                // Bits 3:0 and upper bits stay zero
                rd_word[`GMS_SEL_MSB:`GMS_SEL_LSB] = s_q.sel;  // RQ9
            end
            `GMS_OFS_LOCK_CTRL:
            begin
                rd_word[`GMS_LOCK_BIT] = s_q.lock;
                rd_word[`GMS_IVD_BIT]  = s_q.internal_graphics_disable;
            end
            `GMS_OFS_STATUS:
            begin
                rd_word[`GMS_SIZE_MSB:`GMS_SIZE_LSB] = sel_if.size_mb;
                rd_word[`GMS_SUBC_MSB:`GMS_SUBC_LSB] = sel_if.subclass;
                rd_word[`GMS_CLAIM_BIT]              = sel_if.claim_vga;
            end
            default:
            begin
                rd_word = 32'h0000_0000;
            end
        endcase
    end

    // ============================================================
    // Next state: APB phases and register writes
    always_comb
    begin
        s_d = s_q;
        case (s_q.st)
            APB_IDLE:
            begin
                // First access cycle: answer next cycle
                if (i_psel && i_penable)
                begin
                    s_d.st      = APB_ANSWER;
                    s_d.pready  = 1'b1;
                    s_d.pslverr = !mapped(i_paddr);
                    s_d.prdata  = i_pwrite ? 32'h0000_0000 : rd_word;
                end
            end
            APB_ANSWER:
            begin
                // Completion edge
                s_d.st      = APB_IDLE;
                s_d.pready  = 1'b0;
                s_d.pslverr = 1'b0;
                s_d.prdata  = 32'h0000_0000;
                if (acc_done && i_pwrite && !s_q.lock)  // RQ6
                begin
                    if (i_paddr == `GMS_OFS_GFX_CTRL && wr_sel <= `GMS_SEL_MAX)  // RQ9
                    begin
                        s_d.sel = wr_sel;  // RQ1
                    end
                    if (i_paddr == `GMS_OFS_LOCK_CTRL)
                    begin
                        s_d.internal_graphics_disable  = i_pwdata[`GMS_IVD_BIT];
                        s_d.lock = i_pwdata[`GMS_LOCK_BIT];  // RQ6
                    end
                end
            end
            default:
            begin
                s_d.st     = APB_IDLE;
                s_d.pready = 1'b0;
            end
        endcase
    end

    // ============================================================
    // State register
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q.st      <= APB_IDLE;
            s_q.pready  <= 1'b0;
            s_q.pslverr <= 1'b0;
            s_q.prdata  <= 32'h0000_0000;
            s_q.sel     <= `GMS_SEL_RESET;  // RQ1
            s_q.internal_graphics_disable     <= 1'b0;
            s_q.lock    <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // Decoder instance
    assign sel_if.code = s_q.sel;

    gms_decode u_decode (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .sel_if (sel_if)
    );

    // ============================================================
    // Outputs, all from flip-flops
    assign o_prdata      = s_q.prdata;
    assign o_pready      = s_q.pready;
    assign o_pslverr     = s_q.pslverr;
    assign o_fb_size_mb  = sel_if.size_mb;
    assign o_claim_vga   = sel_if.claim_vga;
    assign o_subclass    = sel_if.subclass;
    assign o_locked      = s_q.lock;
    assign o_gfx_disable = s_q.internal_graphics_disable;

    // ============================================================
    // Checks
    sequence seq_access;
        i_psel && i_penable && !s_q.pready;
    endsequence

    sequence seq_answer;
        ##1 s_q.pready;
    endsequence

    // Select field resets to its documented code
    AST_SEL_RESET: assert property (@(posedge i_mclk)  // RQ1
        $fell(i_rst) |-> s_q.sel == `GMS_SEL_RESET)
        else $error("select field not at reset code");

    // No reservation means no size and no claim
    AST_NONE_NO_CLAIM: assert property (@(posedge i_mclk) disable iff (i_rst)  // RQ2
        s_q.sel == `GMS_SEL_NONE ##1 s_q.sel == `GMS_SEL_NONE
        |-> o_fb_size_mb == 9'h000 && !o_claim_vga)
        else $error("memory reserved or VGA claimed with code 0000");

    // No reservation reports sub-class 80
    AST_NONE_SUBCLASS: assert property (@(posedge i_mclk) disable iff (i_rst)  // RQ3
        s_q.sel == `GMS_SEL_NONE |=> o_subclass == `GMS_SUBC_NOVGA)
        else $error("sub-class not 80 with code 0000");

    // Low codes give 1..16 MB
    AST_SIZE_LOW: assert property (@(posedge i_mclk) disable iff (i_rst)  // RQ4
        s_q.sel == 4'h2 |=> o_fb_size_mb == 9'h004)
        else $error("code 0010 does not reserve 4 MB");

    // High codes give 32..256 MB
    AST_SIZE_HIGH: assert property (@(posedge i_mclk) disable iff (i_rst)  // RQ5
        s_q.sel == 4'h9 |=> o_fb_size_mb == 9'h100 && o_claim_vga)
        else $error("code 1001 does not reserve 256 MB");

    // Locked register never changes
    AST_LOCK_HOLDS: assert property (@(posedge i_mclk) disable iff (i_rst)  // RQ6
        s_q.lock |=> s_q.lock && $stable(s_q.sel) && $stable(s_q.internal_graphics_disable))
        else $error("locked register changed");

    // Reserved codes are never stored
    AST_NO_RESERVED: assert property (@(posedge i_mclk) disable iff (i_rst)  // RQ9
        s_q.sel <= `GMS_SEL_MAX)
        else $error("reserved select code stored");

    // Low nibble reads zero
    AST_LOW_ZERO: assert property (@(posedge i_mclk) disable iff (i_rst)  // RQ9
        s_q.pready && !i_pwrite && i_paddr == `GMS_OFS_GFX_CTRL
        |-> o_prdata[3:0] == 4'h0)
        else $error("reserved bits 3:0 not zero");

    // Every access answered one cycle later
    AST_APB_ANSWER: assert property (@(posedge i_mclk) disable iff (i_rst)
        seq_access |-> seq_answer)
        else $error("APB access not answered in one cycle");

endmodule

// >>> hdl/gms_cfg.svh
// Overview of operation
// RQ1: Select field bits 7:4, resets to 0011b
// RQ2: Code 0000 reserves nothing, no VGA claims
// RQ3: Code 0000 reports sub-class code 80
// RQ4: Codes 0001-0100 reserve 1/4/8/16 MB
// RQ5: Codes 0101-1001 reserve 32/48/64/128/256 MB
// RQ6: Lock bit set makes register read-only
// RQ7: Software avoids 0000 while graphics enabled
// RQ8: Software reserves memory only when graphics enabled
// RQ9: Codes 1010-1111 reserved; bits 3:0 zero
`ifndef GMS_CFG_SVH
`define GMS_CFG_SVH

// ============================================================
// Register byte offsets
`define GMS_OFS_GFX_CTRL   12'h000
`define GMS_OFS_LOCK_CTRL  12'h004
`define GMS_OFS_STATUS     12'h008

// ============================================================
// Field positions
`define GMS_SEL_LSB        4
`define GMS_SEL_MSB        7
`define GMS_LOCK_BIT       0
`define GMS_IVD_BIT        1
`define GMS_SIZE_LSB       0
`define GMS_SIZE_MSB       8
`define GMS_SUBC_LSB       9
`define GMS_SUBC_MSB       16
`define GMS_CLAIM_BIT      17

// ============================================================
// Reset values and codes
`define GMS_SEL_RESET      4'h3
`define GMS_SEL_NONE       4'h0
`define GMS_SEL_MAX        4'h9
`define GMS_SUBC_NOVGA     8'h80
`define GMS_SUBC_VGA       8'h00

// ============================================================
// Reservation sizes in MB
`define GMS_MB_1           9'h001
`define GMS_MB_4           9'h004
`define GMS_MB_8           9'h008
`define GMS_MB_16          9'h010
`define GMS_MB_32          9'h020
`define GMS_MB_48          9'h030
`define GMS_MB_64          9'h040
`define GMS_MB_128         9'h080
`define GMS_MB_256         9'h100

`endif

// >>> hdl/gms_pkg.sv
package gms_pkg;

    // ============================================================
    // APB slave phases
    typedef enum logic [0:0] {
        APB_IDLE,
        APB_ANSWER
    } apb_state_t;

    // Main block state
    typedef struct packed {
        apb_state_t  st;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic [3:0]  sel;
        logic        internal_graphics_disable;
        logic        lock;
    } ctrl_state_t;

    // Decoder state
    typedef struct packed {
        logic [8:0]  size_mb;
        logic        claim_vga;
        logic [7:0]  subclass;
    } dec_state_t;

endpackage

// >>> hdl/gms_if.sv
`timescale 1ns/10ps
// ============================================================
// Select code out, decoded reservation back
interface gms_if;
    logic [3:0] code;       // Current select code
    logic [8:0] size_mb;    // Reserved frame buffer, MB
    logic       claim_vga;  // Legacy VGA claim enable
    logic [7:0] subclass;   // Reported sub-class code

    modport ctrl (output code, input size_mb, input claim_vga, input subclass);
    modport dec  (input code, output size_mb, output claim_vga, output subclass);
endinterface

// >>> hdl/gms_decode.sv
`timescale 1ns/10ps
`include "gms_cfg.svh"
module gms_decode
    import gms_pkg::*;
(
    // Clock and reset
    input  wire logic i_mclk,
    input  wire logic i_rst,
    // Select code and decoded result
    gms_if.dec        sel_if
);

    // ============================================================
    // Code to size lookup
    function automatic logic [8:0] size_of(input logic [3:0] code);
        case (code)
            4'h1:    size_of = `GMS_MB_1;   // RQ4
            4'h2:    size_of = `GMS_MB_4;   // RQ4
            4'h3:    size_of = `GMS_MB_8;   // RQ4
            4'h4:    size_of = `GMS_MB_16;  // RQ4
            4'h5:    size_of = `GMS_MB_32;  // RQ5
            4'h6:    size_of = `GMS_MB_48;  // RQ5
            4'h7:    size_of = `GMS_MB_64;  // RQ5
            4'h8:    size_of = `GMS_MB_128; // RQ5
            4'h9:    size_of = `GMS_MB_256; // RQ5
            default: size_of = 9'h000;      // RQ2
        endcase
    endfunction

    dec_state_t s_q;  // Registered decode
    dec_state_t s_d;  // Next decode

    // ============================================================
    // Decode next state
    always_comb
    begin
        s_d           = s_q;
        s_d.size_mb   = size_of(sel_if.code);
        // No reservation drops VGA claims
        s_d.claim_vga = (sel_if.code != `GMS_SEL_NONE);  // RQ2
        // Sub-class follows the claim
        if (sel_if.code == `GMS_SEL_NONE)
        begin
            s_d.subclass = `GMS_SUBC_NOVGA;  // RQ3
        end
        else
        begin
            s_d.subclass = `GMS_SUBC_VGA;
        end
    end

    // ============================================================
    // State register, reset matches reset code
    always_ff @(posedge i_mclk or posedge i_rst)
    begin
        if (i_rst)
        begin
            s_q.size_mb   <= `GMS_MB_8;
            s_q.claim_vga <= 1'b1;
            s_q.subclass  <= `GMS_SUBC_VGA;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign sel_if.size_mb   = s_q.size_mb;
    assign sel_if.claim_vga = s_q.claim_vga;
    assign sel_if.subclass  = s_q.subclass;

endmodule

// >>> sim/testbench.sv
`timescale 1ns/10ps
module testbench;
    import gms_pkg::*;

    // ============================================================
    // Bench signals
    logic        i_mclk    = 1'b0;   // System clock
    logic        i_rst     = 1'b1;   // Reset, held at start
    logic        i_psel    = 1'b0;   // APB select
    logic        i_penable = 1'b0;   // APB enable
    logic        i_pwrite  = 1'b0;   // APB direction
    logic [11:0] i_paddr   = 12'h000; // APB address
    logic [31:0] i_pwdata  = 32'h0;  // APB write data
    logic [31:0] o_prdata;           // Read data
    logic        o_pready;           // Access done
    logic        o_pslverr;          // Access error
    logic [8:0]  o_fb_size_mb;       // Reserved size
    logic        o_claim_vga;        // VGA claim
    logic [7:0]  o_subclass;         // Sub-class code
    logic        o_locked;           // Lock level
    logic        o_gfx_disable;      // Graphics disable level
    int          fail_count = 0;     // Mismatches
    int          n_checks   = 0;     // Comparisons
    logic [7:0]  rnd        = 8'h59; // Random source, seed 89
    logic [31:0] rd;                 // Last read data
    logic        er;                 // Last error flag
    int          sel_m;              // Model select code
    int          mb_tab [10] = '{0, 1, 4, 8, 16, 32, 48, 64, 128, 256};

    // ============================================================
    // Design under test
    gms_prealloc u_gms_prealloc (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .o_fb_size_mb(o_fb_size_mb), .o_claim_vga(o_claim_vga),
        .o_subclass(o_subclass), .o_locked(o_locked), .o_gfx_disable(o_gfx_disable)
    );

    // Clock, 20 ns period
    initial
    begin
        forever #10 i_mclk = ~i_mclk;
    end

    // Verdict and end of run
    task automatic final_report();
        if (fail_count == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Next random byte
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    // One APB transfer, waits for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_mclk);
        i_psel   <= 1'b1;
        i_pwrite <= w;
        i_paddr  <= a;
        i_pwdata <= d;
        @(posedge i_mclk);
        i_penable <= 1'b1;
        // Values read at the edge are those the design samples there
        do
        begin
            @(posedge i_mclk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        if (n >= 20)
            chk(32'h1, 32'h0);
        rd = o_prdata;
        er = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    // Read back select, decode and status against the model
    task automatic check_all();
        int mb;
        mb = (sel_m == 0) ? 0 : mb_tab[sel_m];
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'(sel_m) << 4);
        chk({23'h0, o_fb_size_mb}, 32'(mb));
        chk({31'h0, o_claim_vga}, {31'h0, sel_m != 0});
        chk({24'h0, o_subclass}, (sel_m == 0) ? 32'h80 : 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, {14'h0, sel_m != 0, (sel_m == 0) ? 8'h80 : 8'h00, 9'(mb)});
    endtask

    // Watchdog
    initial
    begin
        #200000;
        fail_count++;
        final_report();
    end

    // ============================================================
    // Main sequence
    initial
    begin
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        sel_m = 3;
        check_all();
        chk({30'h0, o_locked, o_gfx_disable}, 32'h0);
        for (int c = 0; c < 16; c++)
        begin
            rnd = lfsr(rnd);
            apb(1'b1, 12'h004, {31'h0, c == 0} << 1);
            apb(1'b1, 12'h000, {rnd, rnd, rnd[7:4], 4'(c), rnd[3:0]});
            if (c <= 9)
                sel_m = c;
            check_all();
        end
        // Unmapped access is refused
        apb(1'b1, 12'h00c, 32'h10);
        chk({31'h0, er}, 32'h1);
        apb(1'b0, 12'h00c, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        // Lock freezes select and lock register
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b1, 12'h000, 32'h70);
        apb(1'b1, 12'h004, 32'h2);
        chk({30'h0, o_gfx_disable, o_locked}, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1);
        check_all();
        // Second reset restores defaults
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        sel_m = 3;
        check_all();
        chk({31'h0, o_locked}, 32'h0);
        final_report();
    end
endmodule
